// ==== dv/pin_model.sv ====
`timescale 1ns/1ps
`default_nettype none
module pin_model (
  input wire logic clk_sys,
  input wire logic [15:0] pad_out,
  input wire logic [15:0] pad_oe,
  input wire logic [15:0] pad_pull_up,
  input wire logic [15:0] pad_pull_down,
  output logic [15:0] pad_in
);
  // ------
  // Pin levels
  // ------
  logic [15:0] flt_reg = 16'h0000;
  // Undriven, unpulled pins wander so no level reads right by luck
  always_ff @(posedge clk_sys)
    flt_reg <= ~flt_reg;
  // Released pins fall to their pull resistor
  always_comb
    for (int i = 0; i < 16; i++)
      pad_in[i] = pad_oe[i] ? pad_out[i] : pad_pull_up[i] ? 1'b1 :
        pad_pull_down[i] ? 1'b0 : flt_reg[i];
endmodule : pin_model
`default_nettype wire

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb import gpio_pkg::*;;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [7:0] axi_awaddr = 8'h00, axi_araddr = 8'h00;
  logic [31:0] axi_wdata = 32'h0;
  logic [3:0] axi_wstrb = 4'h0;
  logic axi_awvalid = 1'b0, axi_wvalid = 1'b0, axi_bready = 1'b0;
  logic axi_arvalid = 1'b0, axi_rready = 1'b0;
  logic [127:0] fn_out = 128'h0, fn_oe = 128'h0;
  logic axi_awready, axi_wready, axi_bvalid, axi_arready, axi_rvalid;
  logic [1:0] axi_bresp, axi_rresp, rsp;
  logic [31:0] axi_rdata, pad_drive, rd;
  logic [15:0] pad_in, pad_out, pad_oe, pad_pull_up, pad_pull_down, pad_schmitt_en;
  logic [127:0] fn_in;
  logic ta, tw, tv;
  int mismatches = 0, check_count = 0;

  always #4 clk_sys = ~clk_sys;

  gpio_port gpio_port_inst (.clk_sys, .sys_rst, .axi_awaddr, .axi_awvalid, .axi_awready,
    .axi_wdata, .axi_wstrb, .axi_wvalid, .axi_wready, .axi_bresp, .axi_bvalid, .axi_bready,
    .axi_araddr, .axi_arvalid, .axi_arready, .axi_rdata, .axi_rresp, .axi_rvalid,
    .axi_rready, .pad_in, .pad_out, .pad_oe, .pad_pull_up, .pad_pull_down,
    .pad_schmitt_en, .pad_drive, .fn_out, .fn_oe, .fn_in);
  pin_model pin_model_inst (.clk_sys, .pad_out, .pad_oe, .pad_pull_up, .pad_pull_down,
    .pad_in);

  // ------
  // Bus tasks
  // ------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  // Ready is looked at mid-cycle; inputs only move at rising edges
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_sys);
    axi_awaddr <= a;
    axi_wdata <= d;
    axi_wstrb <= s;
    axi_awvalid <= 1'b1;
    axi_wvalid <= 1'b1;
    axi_bready <= 1'b1;
    forever
    begin
      @(negedge clk_sys);
      ta = axi_awready;
      tw = axi_wready;
      tv = axi_bvalid;
      rsp = axi_bresp;
      @(posedge clk_sys);
      if (ta)
        axi_awvalid <= 1'b0;
      if (tw)
        axi_wvalid <= 1'b0;
      if (tv)
      begin
        axi_bready <= 1'b0;
        break;
      end
    end
  endtask : wr

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, 4'h3);
    wr(a, d, 4'hC);
  endtask : wr32

  task automatic rd_reg(input logic [7:0] a);
    @(posedge clk_sys);
    axi_araddr <= a;
    axi_arvalid <= 1'b1;
    axi_rready <= 1'b1;
    forever
    begin
      @(negedge clk_sys);
      ta = axi_arready;
      tv = axi_rvalid;
      rd = axi_rdata;
      rsp = axi_rresp;
      @(posedge clk_sys);
      if (ta)
        axi_arvalid <= 1'b0;
      if (tv)
      begin
        axi_rready <= 1'b0;
        break;
      end
    end
  endtask : rd_reg

  task automatic settle;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : settle

  task automatic give_verdict;
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict

  // ------
  // Tests
  // ------
  initial
  begin
    repeat (16) @(posedge clk_sys);
    sys_rst <= 1'b0;
    settle();
    chk({pad_pull_up, pad_pull_down}, 32'h2000_4000);
    chk(pad_oe, 32'h0);
    rd_reg(OFS_MODE);
    chk(rd, MODE_RST_DBG);
    rd_reg(OFS_PULL);
    chk(rd, PULL_RST_DBG);
    wr32(OFS_MODE, 32'h0);
    wr32(OFS_PULL, 32'h0000_00C9);
    settle();
    chk({pad_pull_up[3:0], pad_pull_down[3:0], pad_schmitt_en[3:0], pad_oe[3:0]}, 32'h12F0);
    rd_reg(OFS_IN);
    chk(rd[1:0], 32'h1);
    wr32(OFS_MODE, 32'h3);
    settle();
    chk({pad_pull_up[0], pad_schmitt_en[0], pad_oe[0]}, 32'h0);
    rd_reg(OFS_IN);
    chk(rd[0], 32'h0);
    wr32(OFS_OTYPE, 32'h2);
    wr32(OFS_MODE, 32'h55);
    // Full word so set and clear reach one pin together
    wr(OFS_SETCLR, 32'h0002_0003, 4'hF);
    rd_reg(OFS_OUT);
    chk(rd, 32'h3);
    wr(OFS_SETCLR, 32'h0001_0000, 4'hC);
    rd_reg(OFS_OUT);
    chk(rd, 32'h2);
    settle();
    chk({pad_oe[3:0], pad_out[3], pad_out[2], pad_out[0]}, 32'h68);
    chk({pad_pull_up[3:0], pad_pull_down[3:0]}, 32'h12);
    chk(pad_schmitt_en[3:0], 32'hF);
    wr(OFS_SETCLR, 32'h4, 4'h3);
    settle();
    rd_reg(OFS_IN);
    chk(rd[3:0], 32'h4);
    wr32(OFS_DRV, 32'hE4E4);
    wr32(OFS_HIGH_DRIVE_BIT, 32'hF0);
    settle();
    chk(pad_drive[15:0], 32'hAA04);
    wr32(OFS_FSEL_LO, 32'h500);
    wr32(OFS_FSEL_HI, 32'h60);
    wr32(OFS_PULL, 32'h0004_0004);
    wr(OFS_SETCLR, 32'h0004_0000, 4'hC);
    fn_out <= 128'h0020_0000;
    fn_oe <= 128'h0030_0000;
    wr32(OFS_LOCK, 32'h1);
    wr32(OFS_MODE, 32'h0008_0020);
    rd_reg(OFS_MODE);
    chk(rd, 32'h0008_0021);
    settle();
    chk({pad_oe[2], pad_out[2], pad_oe[9]}, 32'h6);
    chk(fn_in[23:16], 32'h20);
    chk(fn_in[79:72], 32'h40);
    chk(pad_pull_up[9], 32'h1);
    // Pin 1 feeds its peripheral from plain input mode
    chk(fn_in[15:8], 32'h1);
    rd_reg(OFS_OUT);
    chk(rd, 32'h2);
    // Park every pin in analog; locked pin 0 stays an output
    wr32(OFS_MODE, 32'hFFFF_FFFF);
    settle();
    chk(pad_schmitt_en, 32'h1);
    chk(pad_oe, 32'h1);
    rd_reg(8'h40);
    chk(rsp, RESP_SLVERR);
    chk(rd, 32'h0);
    wr(8'h40, 32'h1, 4'h3);
    chk(rsp, RESP_SLVERR);
    give_verdict();
  end

  initial
  begin
    #100000;
    mismatches++;
    give_verdict();
  end
endmodule : tb
`default_nettype wire

// ==== rtl/alternate_function_router.sv ====
`timescale 1ns/1ps
`default_nettype none
module alternate_function_router import gpio_pkg::*; (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [SEL_W-1:0] sel,
  input wire logic [FUNC_CHOICES-1:0] fn_out_bus,
  input wire logic [FUNC_CHOICES-1:0] fn_oe_bus,
  input wire logic level,
  output logic sel_out,
  output logic sel_oe,
  output logic [FUNC_CHOICES-1:0] fn_in_bus
);

  // Only the chosen peripheral sees or drives the pin
  assign sel_out = fn_out_bus[sel]; // R13
  assign sel_oe = fn_oe_bus[sel]; // R13

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      fn_in_bus <= '0;
    else
      fn_in_bus <= FUNC_CHOICES'(level) << sel; // R12 R16
  end

  property p_single_route;
    @(posedge clk_sys) disable iff (sys_rst)
      $onehot0(fn_in_bus);
  endproperty
  a_single_route: assert property (p_single_route) else $error("two functions see one pin"); // R13

endmodule : alternate_function_router
`default_nettype wire

// ==== rtl/gpio_pin_cell.sv ====
`timescale 1ns/1ps
`default_nettype none
module gpio_pin_cell import gpio_pkg::*; (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [1:0] mode,
  input wire logic [1:0] pull,
  input wire logic otype,
  input wire logic [2:0] drive,
  input wire logic out_bit,
  input wire logic fn_out,
  input wire logic fn_oe,
  input wire logic pad_in,
  output logic pad_out,
  output logic pad_oe,
  output logic pull_up_en,
  output logic pull_down_en,
  output logic schmitt_en,
  output var drive_e drive_level,
  output logic in_level
);

  logic src;
  logic en;

  // Analog mode cuts the digital input path
  assign in_level = pad_in & (mode != MODE_ANALOG); // R04

  always_comb
  begin
    src = (mode == MODE_FUNC) ? fn_out : out_bit; // R15
    en = (mode == MODE_OUT) || ((mode == MODE_FUNC) && fn_oe); // R16
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      pad_out <= 1'b0;
      pad_oe <= 1'b0;
      pull_up_en <= 1'b0;
      pull_down_en <= 1'b0;
      schmitt_en <= 1'b1;
      drive_level <= DRV_NORMAL;
    end
    else
    begin
      // Open drain only pulls low; high is left to the pull resistor
      pad_out <= src & ~otype; // R05
      pad_oe <= en & (~otype | ~src); // R03 R05
      pull_up_en <= (mode != MODE_ANALOG) && (pull == PULL_UP); // R06 R17
      pull_down_en <= (mode != MODE_ANALOG) && (pull == PULL_DOWN); // R06 R17
      schmitt_en <= (mode != MODE_ANALOG); // R08
      if (drive[2])
        drive_level <= DRV_MAX; // R07
      else if (drive[1:0] == 2'h1)
        drive_level <= DRV_LARGE;
      else
        drive_level <= DRV_NORMAL;
    end
  end

endmodule : gpio_pin_cell
`default_nettype wire

// ==== rtl/gpio_pkg.sv ====
package gpio_pkg;

  // ----------------------------------------
  // Port geometry
  // ----------------------------------------
  localparam int PORT_PINS = 16;
  localparam int FUNC_CHOICES = 8;
  localparam int SEL_W = 3;

  // ----------------------------------------
  // Register byte offsets
  // ----------------------------------------
  localparam logic [7:0] OFS_MODE = 8'h00;
  localparam logic [7:0] OFS_OTYPE = 8'h04;
  localparam logic [7:0] OFS_DRV = 8'h08;
  localparam logic [7:0] OFS_PULL = 8'h0C;
  localparam logic [7:0] OFS_IN = 8'h10;
  localparam logic [7:0] OFS_OUT = 8'h14;
  localparam logic [7:0] OFS_SETCLR = 8'h18;
  localparam logic [7:0] OFS_LOCK = 8'h1C;
  localparam logic [7:0] OFS_FSEL_LO = 8'h20;
  localparam logic [7:0] OFS_FSEL_HI = 8'h24;
  localparam logic [7:0] OFS_HIGH_DRIVE_BIT = 8'h3C;

  // ----------------------------------------
  // Field encodings
  // ----------------------------------------
  localparam logic [1:0] MODE_IN = 2'h0;
  localparam logic [1:0] MODE_OUT = 2'h1;
  localparam logic [1:0] MODE_FUNC = 2'h2;
  localparam logic [1:0] MODE_ANALOG = 2'h3;
  localparam logic [1:0] PULL_UP = 2'h1;
  localparam logic [1:0] PULL_DOWN = 2'h2;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------
  // Reset values and masks
  // ----------------------------------------
  // Debug data pin 13: function, pull-up; debug clock pin 14: function, pull-down
  localparam logic [31:0] MODE_RST_DBG = 32'h2800_0000;
  localparam logic [31:0] PULL_RST_DBG = 32'h2400_0000;
  localparam logic [31:0] CFG_RST = 32'h0000_0000;
  localparam logic [31:0] FSEL_MASK = 32'h7777_7777;

  typedef enum logic [1:0] {DRV_NORMAL, DRV_LARGE, DRV_MAX} drive_e;

endpackage : gpio_pkg

// ==== rtl/gpio_port.sv ====
// Design decisions made here: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// (R01) Reset leaves pins floating input; debug data pin pulled up, clock pulled down.
// (R02) Four input and four output configurations are available per pin.
// (R03) Input mode: pull 00 none, 01 up, 10 down; input readable, driver off.
// (R04) Analog mode: no Schmitt, no digital path, no pull.
// (R05) Output mode drives output data push-pull, or only low when open drain.
// (R06) Output mode pull: 00 or 11 none, 01 up, 10 down.
// (R07) Drive code 1xx maximum, 001 large, others normal.
// (R08) Output mode keeps Schmitt input on so pin level stays readable.
// (R09) Set/clear write sets and clears output bits; set wins over clear.
// (R10) A locked pin ignores configuration writes until reset.
// (R11) Software should use byte or half-word accesses.
// (R12) Eight function choices per pin; low select pins 0-7, high 8-15.
// (R13) Each pin connects to exactly one peripheral signal.
// (R14) Software should use input modes for peripheral inputs.
// (R15) Function mode drives the pin from the peripheral, push-pull or open drain.
// (R16) Function mode lets peripheral control output while its input still arrives.
// (R17) Function mode pull: 00 none, 01 up, 10 down.
// (R18) Software should park unused pins in analog mode.
// (R19) Pins present per port set by a mask; 55 across all ports.
// (R20) Set/clear changes only addressed output bits in one cycle.
// (R21) Output data reads return the latched value, whoever drives the pin.
module gpio_port import gpio_pkg::*; #(
  parameter logic [15:0] PIN_PRESENT = 16'hFFFF,
  parameter bit HAS_DEBUG_PINS = 1'b1
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [7:0] axi_awaddr,
  input wire logic axi_awvalid,
  output logic axi_awready,
  input wire logic [31:0] axi_wdata,
  input wire logic [3:0] axi_wstrb,
  input wire logic axi_wvalid,
  output logic axi_wready,
  output logic [1:0] axi_bresp,
  output logic axi_bvalid,
  input wire logic axi_bready,
  input wire logic [7:0] axi_araddr,
  input wire logic axi_arvalid,
  output logic axi_arready,
  output logic [31:0] axi_rdata,
  output logic [1:0] axi_rresp,
  output logic axi_rvalid,
  input wire logic axi_rready,
  input wire logic [15:0] pad_in,
  output logic [15:0] pad_out,
  output logic [15:0] pad_oe,
  output logic [15:0] pad_pull_up,
  output logic [15:0] pad_pull_down,
  output logic [15:0] pad_schmitt_en,
  output logic [31:0] pad_drive,
  input wire logic [127:0] fn_out,
  input wire logic [127:0] fn_oe,
  output logic [127:0] fn_in
);

  // ----------------------------------------
  // Parameter checks
  // ----------------------------------------
  if (PIN_PRESENT == 16'h0000)
  begin : g_no_pins
    $error("port needs at least one pin");
  end
  if (HAS_DEBUG_PINS && (PIN_PRESENT[14:13] != 2'h3))
  begin : g_no_debug
    $error("debug pins must be present");
  end

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [31:0] mode_reg;
  logic [31:0] pull_reg;
  logic [31:0] drive_strength_reg;
  logic [63:0] fsel_reg;
  logic [15:0] otype_reg;
  logic [15:0] high_drive_reg;
  logic [15:0] out_reg;
  logic [15:0] lock_reg;
  logic [15:0] in_reg;
  logic [15:0] in_level;
  logic [15:0] cfg_ok;
  logic [31:0] bm;

  logic aw_hold_reg;
  logic w_hold_reg;
  logic [7:0] aw_addr_reg;
  logic [31:0] w_data_reg;
  logic [3:0] w_strb_reg;
  logic wr_fire;
  logic wr_ok;
  logic [31:0] rd_word;
  logic rd_ok;

  // ----------------------------------------
  // AXI4-Lite write channel
  // ----------------------------------------
  assign axi_awready = ~aw_hold_reg & ~axi_bvalid;
  assign axi_wready = ~w_hold_reg & ~axi_bvalid;
  assign wr_fire = aw_hold_reg & w_hold_reg & ~axi_bvalid;
  assign bm = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
  assign cfg_ok = ~lock_reg & PIN_PRESENT; // R10 R19

  always_comb
  begin
    wr_ok = 1'b1;
    if (aw_addr_reg == OFS_MODE)
      wr_ok = 1'b1;
    else if (aw_addr_reg == OFS_OTYPE)
      wr_ok = 1'b1;
    else if (aw_addr_reg == OFS_DRV)
      wr_ok = 1'b1;
    else if (aw_addr_reg == OFS_PULL)
      wr_ok = 1'b1;
    else if (aw_addr_reg == OFS_IN)
      wr_ok = 1'b1;
    else if (aw_addr_reg == OFS_OUT)
      wr_ok = 1'b1;
    else if (aw_addr_reg == OFS_SETCLR)
      wr_ok = 1'b1;
    else if (aw_addr_reg == OFS_LOCK)
      wr_ok = 1'b1;
    else if (aw_addr_reg == OFS_FSEL_LO)
      wr_ok = 1'b1;
    else if (aw_addr_reg == OFS_FSEL_HI)
      wr_ok = 1'b1;
    else if (aw_addr_reg == OFS_HIGH_DRIVE_BIT)
      wr_ok = 1'b1;
    else
      wr_ok = 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      aw_hold_reg <= 1'b0;
      w_hold_reg <= 1'b0;
      aw_addr_reg <= 8'h00;
      w_data_reg <= 32'h0000_0000;
      w_strb_reg <= 4'h0;
      axi_bvalid <= 1'b0;
      axi_bresp <= RESP_OKAY;
    end
    else
    begin
      if (axi_awvalid && axi_awready)
      begin
        aw_hold_reg <= 1'b1;
        aw_addr_reg <= axi_awaddr;
      end
      if (axi_wvalid && axi_wready)
      begin
        w_hold_reg <= 1'b1;
        w_data_reg <= axi_wdata;
        w_strb_reg <= axi_wstrb;
      end
      if (wr_fire)
      begin
        aw_hold_reg <= 1'b0;
        w_hold_reg <= 1'b0;
        axi_bvalid <= 1'b1;
        axi_bresp <= wr_ok ? RESP_OKAY : RESP_SLVERR;
      end
      else if (axi_bvalid && axi_bready)
        axi_bvalid <= 1'b0;
    end
  end

  // ----------------------------------------
  // Pin configuration
  // ----------------------------------------
  // Locked or absent pins simply drop their bits of a write
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      mode_reg <= HAS_DEBUG_PINS ? MODE_RST_DBG : CFG_RST; // R01
      pull_reg <= HAS_DEBUG_PINS ? PULL_RST_DBG : CFG_RST; // R01
      drive_strength_reg <= CFG_RST;
      fsel_reg <= {CFG_RST, CFG_RST};
      otype_reg <= 16'h0000;
      high_drive_reg <= 16'h0000;
    end
    else if (wr_fire)
    begin
      for (int k = 0; k < 32; k++)
      begin
        if (bm[k] && cfg_ok[k/2]) // R10
        begin
          if (aw_addr_reg == OFS_MODE)
            mode_reg[k] <= w_data_reg[k]; // R02
          else if (aw_addr_reg == OFS_PULL)
            pull_reg[k] <= w_data_reg[k];
          else if (aw_addr_reg == OFS_DRV)
            drive_strength_reg[k] <= w_data_reg[k];
        end
        if (bm[k] && cfg_ok[k/4] && (aw_addr_reg == OFS_FSEL_LO))
          fsel_reg[k] <= w_data_reg[k] & FSEL_MASK[k]; // R12
        if (bm[k] && cfg_ok[8+k/4] && (aw_addr_reg == OFS_FSEL_HI))
          fsel_reg[32+k] <= w_data_reg[k] & FSEL_MASK[k]; // R12
      end
      for (int k = 0; k < 16; k++)
      begin
        if (bm[k] && cfg_ok[k])
        begin
          if (aw_addr_reg == OFS_OTYPE)
            otype_reg[k] <= w_data_reg[k];
          else if (aw_addr_reg == OFS_HIGH_DRIVE_BIT)
            high_drive_reg[k] <= w_data_reg[k];
        end
      end
    end
  end

  // ----------------------------------------
  // Output data, lock and input sampling
  // ----------------------------------------
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      out_reg <= 16'h0000;
    else if (wr_fire)
    begin
      for (int k = 0; k < 16; k++)
      begin
        if ((aw_addr_reg == OFS_SETCLR) && bm[k] && w_data_reg[k])
          out_reg[k] <= 1'b1; // R09 R20
        else if ((aw_addr_reg == OFS_SETCLR) && bm[16+k] && w_data_reg[16+k])
          out_reg[k] <= 1'b0; // R09 R20
        else if ((aw_addr_reg == OFS_OUT) && bm[k])
          out_reg[k] <= w_data_reg[k];
      end
    end
  end

  // Lock bits only ever set; nothing but reset releases them
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      lock_reg <= 16'h0000;
    else if (wr_fire && (aw_addr_reg == OFS_LOCK))
      lock_reg <= lock_reg | (w_data_reg[15:0] & bm[15:0] & PIN_PRESENT); // R10
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      in_reg <= 16'h0000;
    else
      in_reg <= in_level & PIN_PRESENT; // R03 R08
  end

  // ----------------------------------------
  // AXI4-Lite read channel
  // ----------------------------------------
  assign axi_arready = ~axi_rvalid;

  always_comb
  begin
    rd_word = 32'h0000_0000;
    rd_ok = 1'b1;
    if (axi_araddr == OFS_MODE)
      rd_word = mode_reg;
    else if (axi_araddr == OFS_OTYPE)
      rd_word = {16'h0000, otype_reg};
    else if (axi_araddr == OFS_DRV)
      rd_word = drive_strength_reg;
    else if (axi_araddr == OFS_PULL)
      rd_word = pull_reg;
    else if (axi_araddr == OFS_IN)
      rd_word = {16'h0000, in_reg};
    else if (axi_araddr == OFS_OUT)
      rd_word = {16'h0000, out_reg}; // R21
    else if (axi_araddr == OFS_SETCLR)
      rd_word = 32'h0000_0000;
    else if (axi_araddr == OFS_LOCK)
      rd_word = {16'h0000, lock_reg};
    else if (axi_araddr == OFS_FSEL_LO)
      rd_word = fsel_reg[31:0];
    else if (axi_araddr == OFS_FSEL_HI)
      rd_word = fsel_reg[63:32];
    else if (axi_araddr == OFS_HIGH_DRIVE_BIT)
      rd_word = {16'h0000, high_drive_reg};
    else
      rd_ok = 1'b0;
  end

  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      axi_rvalid <= 1'b0;
      axi_rdata <= 32'h0000_0000;
      axi_rresp <= RESP_OKAY;
    end
    else if (axi_arvalid && axi_arready)
    begin
      axi_rvalid <= 1'b1;
      axi_rdata <= rd_word;
      axi_rresp <= rd_ok ? RESP_OKAY : RESP_SLVERR;
    end
    else if (axi_rready)
      axi_rvalid <= 1'b0;
  end

  // ----------------------------------------
  // Per-pin router and pad cell
  // ----------------------------------------
  for (genvar i = 0; i < PORT_PINS; i++)
  begin : g_pin
    logic r_out;
    logic r_oe;

    alternate_function_router u_route (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .sel(fsel_reg[4*i +: SEL_W]),
      .fn_out_bus(fn_out[8*i +: 8]),
      .fn_oe_bus(fn_oe[8*i +: 8]),
      .level(in_level[i]),
      .sel_out(r_out),
      .sel_oe(r_oe),
      .fn_in_bus(fn_in[8*i +: 8])
    );

    gpio_pin_cell u_cell (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .mode(mode_reg[2*i +: 2]),
      .pull(pull_reg[2*i +: 2]),
      .otype(otype_reg[i]),
      .drive({high_drive_reg[i], drive_strength_reg[2*i +: 2]}),
      .out_bit(out_reg[i]),
      .fn_out(r_out),
      .fn_oe(r_oe),
      .pad_in(pad_in[i]),
      .pad_out(pad_out[i]),
      .pad_oe(pad_oe[i]),
      .pull_up_en(pad_pull_up[i]),
      .pull_down_en(pad_pull_down[i]),
      .schmitt_en(pad_schmitt_en[i]),
      .drive_level(pad_drive[2*i +: 2]),
      .in_level(in_level[i])
    );
  end

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  logic [15:0] m_in;
  logic [15:0] m_out;
  logic [15:0] m_an;
  logic [15:0] m_fn;
  logic [15:0] drv_max;
  logic [31:0] lock2;

  always_comb
  begin
    for (int k = 0; k < 16; k++)
    begin
      m_in[k] = mode_reg[2*k +: 2] == MODE_IN;
      m_out[k] = mode_reg[2*k +: 2] == MODE_OUT;
      m_an[k] = mode_reg[2*k +: 2] == MODE_ANALOG;
      m_fn[k] = mode_reg[2*k +: 2] == MODE_FUNC;
      drv_max[k] = pad_drive[2*k +: 2] == DRV_MAX;
      lock2[2*k] = lock_reg[k];
      lock2[2*k+1] = lock_reg[k];
    end
  end

  property p_reset_state;
    @(posedge clk_sys) disable iff (sys_rst)
      $fell(sys_rst) |=> (pad_oe == 16'h0000)
        && (pad_pull_up == (HAS_DEBUG_PINS ? 16'h2000 : 16'h0000))
        && (pad_pull_down == (HAS_DEBUG_PINS ? 16'h4000 : 16'h0000));
  endproperty
  a_reset_state: assert property (p_reset_state) else $error("bad pin state after reset"); // R01

  property p_input_no_drive;
    @(posedge clk_sys) disable iff (sys_rst)
      (m_in != 16'h0000) |=> (($past(m_in) & pad_oe) == 16'h0000);
  endproperty
  a_input_no_drive: assert property (p_input_no_drive) else $error("input pin driven"); // R03

  property p_analog_quiet;
    @(posedge clk_sys) disable iff (sys_rst)
      (m_an != 16'h0000) |=>
        (($past(m_an) & (pad_pull_up | pad_pull_down | pad_schmitt_en | pad_oe)) == 16'h0000);
  endproperty
  a_analog_quiet: assert property (p_analog_quiet) else $error("analog pin not quiet"); // R04

  property p_push_pull;
    @(posedge clk_sys) disable iff (sys_rst)
      ((m_out & ~otype_reg) != 16'h0000) |=>
        (($past(m_out & ~otype_reg) & (~pad_oe | (pad_out ^ $past(out_reg)))) == 16'h0000);
  endproperty
  a_push_pull: assert property (p_push_pull) else $error("push-pull pin wrong"); // R05

  property p_open_drain;
    @(posedge clk_sys) disable iff (sys_rst)
      ((m_out & otype_reg) != 16'h0000) |=>
        (($past(m_out & otype_reg) & (pad_out | (pad_oe ^ ~$past(out_reg)))) == 16'h0000);
  endproperty
  a_open_drain: assert property (p_open_drain) else $error("open-drain pin wrong"); // R05

  property p_drive_max;
    @(posedge clk_sys) disable iff (sys_rst)
      (high_drive_reg != 16'h0000) |=> (($past(high_drive_reg) & ~drv_max) == 16'h0000);
  endproperty
  a_drive_max: assert property (p_drive_max) else $error("drive not maximum"); // R07

  property p_schmitt_out;
    @(posedge clk_sys) disable iff (sys_rst)
      (m_out != 16'h0000) |=> (($past(m_out) & ~pad_schmitt_en) == 16'h0000);
  endproperty
  a_schmitt_out: assert property (p_schmitt_out) else $error("output pin lost input"); // R08

  property p_set_wins;
    @(posedge clk_sys) disable iff (sys_rst)
      (wr_fire && (aw_addr_reg == OFS_SETCLR)) |=>
        ((out_reg & $past(w_data_reg[15:0] & bm[15:0])) == $past(w_data_reg[15:0] & bm[15:0]));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("set bit not applied"); // R09

  property p_lock_freeze;
    @(posedge clk_sys) disable iff (sys_rst)
      wr_fire |=> (($past(lock2) & (mode_reg ^ $past(mode_reg))) == 32'h0000_0000);
  endproperty
  a_lock_freeze: assert property (p_lock_freeze) else $error("locked pin changed"); // R10

  logic [15:0] fn_oe_sel;
  always_comb
  begin
    for (int k = 0; k < 16; k++)
      fn_oe_sel[k] = fn_oe[8*k + int'(fsel_reg[4*k +: SEL_W])];
  end

  property p_func_drive;
    @(posedge clk_sys) disable iff (sys_rst)
      ((m_fn & ~otype_reg) != 16'h0000) |=> (($past(m_fn & ~otype_reg) & pad_oe) ==
        ($past(m_fn & ~otype_reg) & $past(fn_oe_sel)));
  endproperty
  a_func_drive: assert property (p_func_drive) else $error("function pin enable wrong"); // R15

  property p_read_out;
    @(posedge clk_sys) disable iff (sys_rst)
      (axi_arvalid && axi_arready && (axi_araddr == OFS_OUT)) |=>
        axi_rvalid && (axi_rdata[15:0] == $past(out_reg));
  endproperty
  a_read_out: assert property (p_read_out) else $error("output data read wrong"); // R21

  c_setclr: cover property (@(posedge clk_sys) wr_fire && (aw_addr_reg == OFS_SETCLR));
  c_lock: cover property (@(posedge clk_sys) wr_fire && (aw_addr_reg == OFS_LOCK));
  c_func: cover property (@(posedge clk_sys) (m_fn & pad_oe) != 16'h0000);

endmodule : gpio_port
`default_nettype wire
